// file: rtl/porg_top.v
// Power-on reset gating sequencer: detector combining, shifter check, reset and programming gate
`include "porg_defines.vh"

module porg_top #(
    parameter RAMP_CYC = `PORG_RAMP_CYC,
    parameter CHK_CYC = `PORG_SHIFT_CHK_CYC
) (
    // Clock and reset
    input wire clk,
    input wire arst_n,
    // Detector outputs, high when supply is above trip level
    input wire backup_battery_supply_ok,
    input wire core_supply_ok,
    input wire io_predriver_supply_ok,
    // Level shifter loopback echoes
    input wire pd_shifter_echo,
    input wire config_pin_shifter_echo,
    // Level shifter test drive
    output reg shifter_test_drive,
    // Reset and permission outputs
    output reg main_reset_n,
    output reg program_enable,
    output reg io_tristate,
    output reg user_mode,
    output reg ramp_fail,
    output reg [`PORG_NUM_SUP-1:0] supply_low
);
    wire [`PORG_NUM_SUP-1:0] det_raw;
    wire [`PORG_NUM_SUP-1:0] det_ok;
    wire pd_echo_s;
    wire pgm_echo_s;
    wire all_ok;
    wire any_ok;
    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [`PORG_CNT_W-1:0] cnt_reg;
    reg [`PORG_CNT_W-1:0] cnt_next;
    reg drive_next;
    genvar i;

    assign det_raw[`PORG_SUP_BAT] = backup_battery_supply_ok;
    assign det_raw[`PORG_SUP_CORE] = core_supply_ok;
    assign det_raw[`PORG_SUP_PD] = io_predriver_supply_ok;

    // One synchroniser per detector, each watched alone
    generate
        for (i = 0; i < `PORG_NUM_SUP; i = i + 1) begin : g_det
            porg_sync u_sync (
                .clk(clk),
                .arst_n(arst_n),
                .d(det_raw[i]),
                .q(det_ok[i])
            );
        end
    endgenerate

    // Shifter echo synchronisers
    porg_sync u_pd_echo (
        .clk(clk),
        .arst_n(arst_n),
        .d(pd_shifter_echo),
        .q(pd_echo_s)
    );
    porg_sync u_pgm_echo (
        .clk(clk),
        .arst_n(arst_n),
        .d(config_pin_shifter_echo),
        .q(pgm_echo_s)
    );

    // Sequencer state codes
    localparam [2:0] ST_RESET = `PORG_ST_RESET;
    localparam [2:0] ST_RAMP = `PORG_ST_RAMP;
    localparam [2:0] ST_CHECK = `PORG_ST_CHECK;
    localparam [2:0] ST_USER = `PORG_ST_USER;
    localparam [2:0] ST_FAIL = `PORG_ST_FAIL;

    // Decoded next-state strobes
    wire enter_user;
    wire enter_fail;

    // AND of all detectors gates the reset
    assign all_ok = &det_ok;
    assign any_ok = |det_ok; // Ramp started

    // Next state is user mode or fault
    assign enter_user = (state_next == ST_USER);
    assign enter_fail = (state_next == ST_FAIL);

    // Next-state logic
    always @* begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        drive_next = shifter_test_drive;
        case (state_reg)
            ST_RESET: begin
                // Timer idle, shifters undriven
                cnt_next = {`PORG_CNT_W{1'b0}};
                drive_next = 1'b0;
                if (any_ok) begin
                    state_next = ST_RAMP;
                end
            end
            ST_RAMP: begin
                // Ramp timer runs until all supplies are up
                cnt_next = cnt_reg + 1'b1;
                if (all_ok) begin
                    state_next = ST_CHECK;
                    cnt_next = {`PORG_CNT_W{1'b0}};
                    drive_next = 1'b1;
                end else if (!any_ok) begin
                    // All supplies gone again, start over
                    state_next = ST_RESET;
                end else if (cnt_reg >= RAMP_CYC[`PORG_CNT_W-1:0] - 1'b1) begin
                    state_next = ST_FAIL;
                end
            end
            ST_CHECK: begin
                // Each shifter phase lasts the check count
                cnt_next = cnt_reg + 1'b1;
                if (!all_ok) begin
                    state_next = ST_RESET;
                end else if (cnt_reg >= CHK_CYC[`PORG_CNT_W-1:0] - 1'b1) begin
                    // Drive high, then low; echoes must follow
                    if (shifter_test_drive) begin
                        if (pd_echo_s && pgm_echo_s) begin
                            drive_next = 1'b0;
                            cnt_next = {`PORG_CNT_W{1'b0}};
                        end else begin
                            // Stuck shifter, stay in reset until a power cycle
                            state_next = ST_FAIL;
                        end
                    end else begin
                        if (!pd_echo_s && !pgm_echo_s) begin
                            state_next = ST_USER;
                        end else begin
                            state_next = ST_FAIL;
                        end
                    end
                end
            end
            ST_USER: begin
                // Any supply drop throws the device back
                if (!all_ok) begin
                    state_next = ST_RESET;
                end
            end
            ST_FAIL: begin
                // Sticky until a full power cycle
                drive_next = 1'b0;
                if (!any_ok) begin
                    state_next = ST_RESET; // Power cycle retries
                end
            end
            default: begin
                state_next = ST_RESET;
            end
        endcase
    end

    // State register
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= ST_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // Ramp and check timer
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg <= {`PORG_CNT_W{1'b0}};
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    // Level shifter test drive
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            shifter_test_drive <= 1'b0;
        end else begin
            shifter_test_drive <= drive_next;
        end
    end

    // Main reset, released only in user mode
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            main_reset_n <= 1'b0;
        end else begin
            main_reset_n <= enter_user;
        end
    end

    // Programming permission, needs every detector released
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            program_enable <= 1'b0;
        end else begin
            program_enable <= enter_user && all_ok;
        end
    end

    // I/O pins float outside user mode, tristate set in reset
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            io_tristate <= 1'b1;
        end else begin
            io_tristate <= !enter_user;
        end
    end

    // User mode flag
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            user_mode <= 1'b0;
        end else begin
            user_mode <= enter_user;
        end
    end

    // Fault flag, ramp timeout or shifter check failure
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ramp_fail <= 1'b0;
        end else begin
            ramp_fail <= enter_fail;
        end
    end

    // Per-detector low flags
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            supply_low <= {`PORG_NUM_SUP{1'b1}};
        end else begin
            supply_low <= ~det_ok;
        end
    end
endmodule

// file: rtl/porg_defines.vh
// Shared constants for the power-on reset gating block
`ifndef PORG_DEFINES_VH
`define PORG_DEFINES_VH

// Monitored supplies
`define PORG_NUM_SUP 3
`define PORG_SUP_BAT 0
`define PORG_SUP_CORE 1
`define PORG_SUP_PD 2

// Timing figures
`define PORG_CLK_HZ 10000000
`define PORG_RAMP_US 100
`define PORG_RAMP_CYC ((`PORG_RAMP_US * (`PORG_CLK_HZ / 1000000)) > 0 ? \
    (`PORG_RAMP_US * (`PORG_CLK_HZ / 1000000)) : 1)
`define PORG_SHIFT_CHK_CYC 4
`define PORG_CNT_W 24

// Sequencer states
`define PORG_ST_RESET 3'h0
`define PORG_ST_RAMP 3'h1
`define PORG_ST_CHECK 3'h2
`define PORG_ST_USER 3'h3
`define PORG_ST_FAIL 3'h4

`endif

// file: rtl/porg_sync.v
// Two-flop synchroniser for one bit, resets to the asserted-low level
module porg_sync (
    // Clock and reset
    input wire clk,
    input wire arst_n,
    // Async in, synced out
    input wire d,
    output reg q
);
    reg meta_reg;

    // First flop feeds only the second
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_reg <= 1'b0;
            q <= 1'b0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule

// file: tb/porg_shifter_model.sv
// Loopback model of the two level shifters seen by the reset sequencer
module porg_shifter_model (
    // Clock
    input wire logic clk,
    // Test drive and fault control
    input wire logic drive,
    input wire logic stuck,
    // Echoes back to the sequencer
    output logic pd_echo,
    output logic cp_echo
);
    timeunit 1ns;
    timeprecision 1ns;
    // Echo one cycle late; a stuck shifter never follows the drive
    always @(posedge clk) begin
        pd_echo <= stuck ? 1'b0 : drive;
        cp_echo <= stuck ? 1'b0 : drive;
    end
    initial pd_echo = 1'b0;
    initial cp_echo = 1'b0;
endmodule

// file: tb/porg_top_assertions.sv
// Checker for the power-on reset gating outputs
module porg_top_assertions (
    // Clock, reset and inputs
    input wire logic clk,
    input wire logic arst_n,
    input wire logic backup_battery_supply_ok,
    input wire logic core_supply_ok,
    input wire logic io_predriver_supply_ok,
    // Outputs watched
    input wire logic shifter_test_drive,
    input wire logic main_reset_n,
    input wire logic program_enable,
    input wire logic io_tristate,
    input wire logic user_mode,
    input wire logic ramp_fail,
    input wire logic [2:0] supply_low
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_low_holds_reset: assert property (|supply_low |-> ##[0:1] !main_reset_n)
        else $error("reset released with a supply low");
    a_low_blocks_prog: assert property (|supply_low |-> ##[0:1] !program_enable)
        else $error("programming allowed with a supply low");
    a_user_drop_reset: assert property (user_mode && !(backup_battery_supply_ok
        && core_supply_ok && io_predriver_supply_ok) |-> ##[1:3] !main_reset_n)
        else $error("supply drop in user mode not reset");
    a_tristate_user: assert property (io_tristate != user_mode)
        else $error("pins released outside user mode");
    a_reset_user: assert property (main_reset_n == user_mode)
        else $error("main reset and user mode disagree");
    a_fail_held: assert property (ramp_fail |-> !main_reset_n && io_tristate)
        else $error("fault state left pins or reset free");
    a_release_late: assert property ($rose(main_reset_n) |-> $past(supply_low) == 3'h0)
        else $error("reset released before last supply");
    a_check_first: assert property ($rose(shifter_test_drive) |-> !main_reset_n [*8])
        else $error("reset released during shifter check");
    a_battery_flag: assert property ($fell(backup_battery_supply_ok) |->
        ##[1:4] supply_low[0])
        else $error("battery loss not flagged");
endmodule
bind porg_top porg_top_assertions u_porg_top_assertions (.*);

// file: tb/porg_top_bench.sv
// Bench for the power-on reset gating sequencer
module porg_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, arst_n = 0, stuck = 0;
    logic [2:0] sup = 3'h0;
    logic pd_echo, cp_echo, drive, mrst_n, prog_en, tri_s, user, rfail;
    logic [2:0] low;
    int fails = 0, checked = 0;
    porg_top #(.RAMP_CYC(20), .CHK_CYC(4)) u_porg_top (.clk(clk), .arst_n(arst_n),
        .backup_battery_supply_ok(sup[0]), .core_supply_ok(sup[1]),
        .io_predriver_supply_ok(sup[2]), .pd_shifter_echo(pd_echo),
        .config_pin_shifter_echo(cp_echo), .shifter_test_drive(drive), .main_reset_n(mrst_n),
        .program_enable(prog_en), .io_tristate(tri_s), .user_mode(user), .ramp_fail(rfail),
        .supply_low(low));
    porg_shifter_model u_porg_shifter_model (.clk(clk), .drive(drive), .stuck(stuck),
        .pd_echo(pd_echo), .cp_echo(cp_echo));
    initial forever #50 clk = ~clk;
    task automatic check(input logic [2:0] seen, input logic [2:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask
    task automatic wait_user;
        for (int i = 0; i < 40 && user !== 1'b1; i++) cyc(1);
        check(user, 1'b1);
        check(prog_en, 1'b1);
        check(tri_s, 1'b0);
    endtask
    task automatic power_off;
        sup = 3'h0;
        cyc(6);
        check(mrst_n, 1'b0);
        check(low, 3'h7);
        check(rfail, 1'b0);
    endtask
    task automatic power_up;
        sup = 3'h1; // battery first
        cyc(6);
        check(mrst_n, 1'b0);
        sup = 3'h3;
        cyc(6);
        check(prog_en, 1'b0);
        check(low, 3'h4);
        sup = 3'h7;
        wait_user();
    endtask
    task automatic drops;
        for (int s = 0; s < 3; s++) begin
            sup = 3'h7 & ~(3'h1 << s);
            cyc(4);
            check(mrst_n, 1'b0);
            check(low, 3'h1 << s);
            check(prog_en, 1'b0);
            sup = 3'h7;
            wait_user();
        end
    endtask
    task automatic faults;
        power_off();
        sup = 3'h6; // battery missing
        cyc(30);
        check(rfail, 1'b1);
        check(tri_s, 1'b1);
        power_off();
        sup = 3'h2;
        cyc(6);
        sup = 3'h0;
        cyc(25);
        check(rfail, 1'b0);
        check(mrst_n, 1'b0);
        stuck = 1'b1;
        sup = 3'h7;
        cyc(20);
        check(rfail, 1'b1);
        check(mrst_n, 1'b0);
        stuck = 1'b0;
        power_off();
        sup = 3'h7;
        wait_user();
    endtask
    task automatic print_verdict;
        if (fails == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        cyc(12);
        check(mrst_n, 1'b0);
        arst_n = 1'b1;
        cyc(3);
        check(mrst_n, 1'b0);
        power_up();
        drops();
        faults();
        arst_n = 1'b0;
        cyc(1);
        check(mrst_n, 1'b0);
        print_verdict();
    end
    initial begin
        #(3000 * 100);
        fails++;
        print_verdict();
    end
endmodule
